/* design/repeater_cfg.svh */
// Purpose: Timing counts and reset levels of the dual bus repeater logic.
// Assumes: Counts are in sys_clk cycles at 125 MHz.
// Notes:   Counts are defaults only; the top module takes them as parameters.
`ifndef REPEATER_CFG_SVH
`define REPEATER_CFG_SVH

// Clock period in ns, for reading the counts as times
`define RPT_CLK_PERIOD_NS 8
// Dominant timeout, in clock cycles
`define RPT_TDOM_CYCLES 125000
// Reception hold-off after own dominant ends, in clock cycles
`define RPT_SUPPRESS_CYCLES 16
// Recessive level on every digital line
`define RPT_RECESSIVE 1'b1
// Synchroniser depth
`define RPT_SYNC_STAGES 2

`endif

/* design/repeater_pkg.sv */
// Purpose: Types shared by the dual bus repeater logic.
// Assumes: Nothing beyond the cfg header.
// Notes:   Levels are bus polarity: 0 dominant, 1 recessive.
package repeater_pkg;

    typedef enum logic [1:0] {
        SUPP_IDLE  = 2'b00,
        SUPP_DRIVE = 2'b01,
        SUPP_HOLD  = 2'b10
    } supp_state_e;

    typedef logic bus_level_t;

endpackage

/* design/dominant_timer.sv */
// Purpose: Dominant timeout on one line; dominant turns recessive after LIMIT cycles.
// Assumes: level_in already synchronous to sys_clk.
// Notes:   Output stays recessive until the input itself goes recessive again.
`timescale 1ns/1ns
`include "repeater_cfg.svh"

module dominant_timer #(
    parameter int unsigned LIMIT = `RPT_TDOM_CYCLES,
    parameter int unsigned W = $clog2(LIMIT + 1)
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic level_in,
    output logic level_out
);
    import repeater_pkg::*;

    localparam logic [W-1:0] LIMIT_W = W'(LIMIT);

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    logic level_out_r;
    wire expired = (count_r == LIMIT_W);
    wire level_out_nxt = level_in | expired;

    assign count_nxt = level_in ? '0 : (expired ? count_r : count_r + W'(1));
    assign level_out = level_out_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
            level_out_r <= `RPT_RECESSIVE;
        end else begin
            count_r <= count_nxt;
            level_out_r <= level_out_nxt;
        end
    end

    a_timer_expiry: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (!level_in && count_r == LIMIT_W) |=> level_out_r)
        else $error("timer kept dominant past its limit");

    a_timer_passes: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (!level_in && count_r < LIMIT_W) |=> !level_out_r)
        else $error("timer dropped dominant early");

endmodule

/* design/dual_can_repeater_logic.sv */
// Purpose: Repeater and feedback suppression logic joining a controller to two buses.
// Assumes: Bus receive inputs are comparator results, 0 when the bus is dominant.
// Notes:   Four clock edges of latency from transmit and receive inputs to any output; three from the enables to the bus transmits.
`timescale 1ns/1ns
`include "repeater_cfg.svh"

module dual_can_repeater_logic #(
    parameter int unsigned TDOM_CYCLES = `RPT_TDOM_CYCLES,
    parameter int unsigned SUPPRESS_CYCLES = `RPT_SUPPRESS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire repeater_pkg::bus_level_t local_transmit_input,
    input wire repeater_pkg::bus_level_t expansion_transmit_input,
    input wire logic bus_one_enable_n,
    input wire logic bus_two_enable_n,
    input wire repeater_pkg::bus_level_t bus_one_receive,
    input wire repeater_pkg::bus_level_t bus_two_receive,
    output repeater_pkg::bus_level_t local_receive_output,
    output repeater_pkg::bus_level_t expansion_receive_output,
    output repeater_pkg::bus_level_t bus_one_transmit,
    output repeater_pkg::bus_level_t bus_two_transmit
);
    import repeater_pkg::*;

    localparam int SW = $clog2(SUPPRESS_CYCLES + 1);
    localparam logic [SW-1:0] SUPP_LAST = SW'(SUPPRESS_CYCLES);

    // Index map for the synchronised lines
    localparam int I_TX = 0;
    localparam int I_TEXT = 1;
    localparam int I_EN1 = 2;
    localparam int I_EN2 = 3;
    localparam int I_RX1 = 4;
    localparam int I_RX2 = 5;
    localparam int NIN = 6;

    logic [NIN-1:0] meta_r;
    logic [NIN-1:0] sync_r;
    wire [NIN-1:0] raw_in = {bus_two_receive, bus_one_receive, bus_two_enable_n,
                             bus_one_enable_n, expansion_transmit_input,
                             local_transmit_input};

    // Reset value is the pulled-up level, so an open input starts recessive
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '1;
            sync_r <= '1;
        end else begin
            meta_r <= raw_in;
            sync_r <= meta_r;
        end
    end

    wire en1 = !sync_r[I_EN1];
    wire en2 = !sync_r[I_EN2];

    // Receive result gated by enable before its timer, as the comparator gate does
    wire rx1_gated = sync_r[I_RX1] | !en1;
    wire rx2_gated = sync_r[I_RX2] | !en2;

    logic tx_timed;
    logic text_timed;
    logic rx1_timed;
    logic rx2_timed;

    dominant_timer #(.LIMIT(TDOM_CYCLES)) u_tmr_tx (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .level_in(sync_r[I_TX]),
        .level_out(tx_timed)
    );
    dominant_timer #(.LIMIT(TDOM_CYCLES)) u_tmr_text (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .level_in(sync_r[I_TEXT]),
        .level_out(text_timed)
    );
    dominant_timer #(.LIMIT(TDOM_CYCLES)) u_tmr_rx1 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .level_in(rx1_gated),
        .level_out(rx1_timed)
    );
    dominant_timer #(.LIMIT(TDOM_CYCLES)) u_tmr_rx2 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .level_in(rx2_gated),
        .level_out(rx2_timed)
    );

    // Dominant-true views of the timed lines
    wire tx_dom = !tx_timed;
    wire text_dom = !text_timed;
    wire [1:0] en_now = {en2, en1};
    wire [1:0] rx_raw_dom = {!rx2_timed, !rx1_timed};
    wire [1:0] masked;
    wire [1:0] rx_dom = rx_raw_dom & ~masked;

    // Own bus is never repeated onto itself; that would latch the bus dominant
    wire any_tx = tx_dom | text_dom;
    wire [1:0] drive_dom = en_now & ({2{any_tx}} | {rx_dom[0], rx_dom[1]});

    wire local_rx_nxt = !(any_tx | rx_dom[0] | rx_dom[1]);
    wire exp_rx_nxt = !(tx_dom | rx_dom[0] | rx_dom[1]);

    logic local_rx_r;
    logic exp_rx_r;
    logic [1:0] bus_tx_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            local_rx_r <= `RPT_RECESSIVE;
            exp_rx_r <= `RPT_RECESSIVE;
            bus_tx_r <= '1;
        end else begin
            local_rx_r <= local_rx_nxt;
            exp_rx_r <= exp_rx_nxt;
            bus_tx_r <= ~drive_dom;
        end
    end

    assign local_receive_output = local_rx_r;
    assign expansion_receive_output = exp_rx_r;
    assign bus_one_transmit = bus_tx_r[0];
    assign bus_two_transmit = bus_tx_r[1];

    // Feedback suppression, one machine per bus
    for (genvar b = 0; b < 2; b++) begin : g_supp
        supp_state_e state_r;
        supp_state_e state_nxt;
        logic [SW-1:0] hold_r;
        logic [SW-1:0] hold_nxt;
        wire driving = !bus_tx_r[b];

        always_comb begin
            state_nxt = state_r;
            hold_nxt = hold_r;
            case (state_r)
                SUPP_IDLE: begin
                    if (driving) begin
                        state_nxt = SUPP_DRIVE;
                    end
                end
                SUPP_DRIVE: begin
                    if (!driving) begin
                        state_nxt = SUPP_HOLD;
                        hold_nxt = SW'(1);
                    end
                end
                SUPP_HOLD: begin
                    if (driving) begin
                        state_nxt = SUPP_DRIVE;
                    end else if (hold_r >= SUPP_LAST) begin
                        state_nxt = SUPP_IDLE;
                    end else begin
                        hold_nxt = hold_r + SW'(1);
                    end
                end
                default: begin
                    state_nxt = SUPP_IDLE;
                end
            endcase
        end

        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                state_r <= SUPP_IDLE;
                hold_r <= '0;
            end else begin
                state_r <= state_nxt;
                hold_r <= hold_nxt;
            end
        end

        // Driving also masks at once, closing the loop before the state catches up
        assign masked[b] = driving || (state_r != SUPP_IDLE);
    end

    // Checks

    a_disabled_bus_quiet: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !en1 |=> bus_one_transmit)
        else $error("disabled bus one was driven dominant");

    a_disabled_two_quiet: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !en2 |=> bus_two_transmit)
        else $error("disabled bus two was driven dominant");

    a_tx_drives_bus: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (tx_dom && en1) |=> !bus_one_transmit)
        else $error("local transmit did not drive enabled bus one");

    a_text_drives_bus: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (text_dom && en2) |=> !bus_two_transmit)
        else $error("expansion transmit did not drive enabled bus two");

    a_tx_to_both_rx: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        tx_dom |=> (!local_receive_output && !expansion_receive_output))
        else $error("local transmit missing on a receive output");

    a_text_not_echoed: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (text_dom && !tx_dom && rx_dom == 2'b00)
            |=> (!local_receive_output && expansion_receive_output))
        else $error("expansion transmit misrouted");

    a_rx_repeats_over: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (rx_dom[0] && en2) |=> (!bus_two_transmit && !local_receive_output
            && !expansion_receive_output))
        else $error("bus one dominant not repeated");

    a_all_recessive: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (!any_tx && rx_dom == 2'b00) |=> (bus_tx_r == 2'b11 && local_receive_output))
        else $error("dominant without any source");

    a_hold_off_mask: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        ($rose(bus_one_transmit) && !drive_dom[0]) |-> masked[0] [*2])
        else $error("bus one reception unmasked too soon");

    // Reset reloads the pulled-up level, so the two edges after it are skipped
    a_sync_two_stage: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        ($past(reset_n) && $past(reset_n, 2))
            |-> (sync_r[I_TX] == $past(local_transmit_input, 2)))
        else $error("transmit input not delayed by two flops");

endmodule

/* testbench/bus_model.sv */
// Purpose: One physical bus seen as a wired-AND of the repeater and one other node.
// Assumes: Low level is dominant on both drivers and on the result.
// Notes:   Zero delay; the repeater's registered outputs give the loop its latency.
`timescale 1ns/1ns

module bus_model (
    input wire logic dev_drive,
    input wire logic node_drive,
    output logic level
);
    // Any active driver wins; recessive only when both are passive
    assign level = dev_drive & node_drive;
endmodule

/* testbench/dual_can_repeater_logic_bench.sv */
// Purpose: Self-checking bench for the dual bus repeater logic.
// Assumes: Output latency of at most four edges; short timeout and hold-off counts.
// Notes:   Other nodes on each bus are driven by the bench through bus_model.
`timescale 1ns/1ns

module dual_can_repeater_logic_bench;
    import repeater_pkg::*;
    localparam int unsigned TDOM = 20;
    localparam int unsigned SUPP = 3;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic tx = 1'b1;
    logic text = 1'b1;
    logic en_one_n = 1'b0;
    logic en_two_n = 1'b0;
    logic node_one = 1'b1;
    logic node_two = 1'b1;
    logic b1_rx, b2_rx, lrx, erx, b1_tx, b2_tx;
    int num_errors = 0;
    int compares = 0;

    always #4 sys_clk = ~sys_clk;

    dual_can_repeater_logic #(.TDOM_CYCLES(TDOM), .SUPPRESS_CYCLES(SUPP)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n),
        .local_transmit_input(tx), .expansion_transmit_input(text),
        .bus_one_enable_n(en_one_n), .bus_two_enable_n(en_two_n),
        .bus_one_receive(b1_rx), .bus_two_receive(b2_rx),
        .local_receive_output(lrx), .expansion_receive_output(erx),
        .bus_one_transmit(b1_tx), .bus_two_transmit(b2_tx)
    );
    bus_model u_bus_one (.dev_drive(b1_tx), .node_drive(node_one), .level(b1_rx));
    bus_model u_bus_two (.dev_drive(b2_tx), .node_drive(node_two), .level(b2_rx));

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Order: local receive, expansion receive, bus one, bus two
    task automatic chk(input string what, input logic [3:0] exp);
        #1;
        compares++;
        if ({lrx, erx, b1_tx, b2_tx} !== exp) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", what, exp, {lrx, erx, b1_tx, b2_tx});
        end
    endtask

    task automatic t_reset();
        step(2);
        chk("after reset", 4'hF);
        @(posedge sys_clk) tx <= 1'b0;
        step(6);
        reset_n <= 1'b0;
        chk("mid reset", 4'hF);
        @(posedge sys_clk) reset_n <= 1'b1;
        tx <= 1'b1;
        step(6);
        $display("done t_reset");
    endtask

    task automatic t_tx();
        for (int e = 0; e < 4; e++) begin
            @(posedge sys_clk) {en_one_n, en_two_n} <= e[1:0];
            tx <= 1'b0;
            step(6);
            chk("tx dominant", {2'b00, e[1:0]});
            @(posedge sys_clk) tx <= 1'b1;
            step(6 + SUPP);
            chk("tx released", 4'hF);
        end
        $display("done t_tx");
    endtask

    task automatic t_text();
        for (int e = 0; e < 4; e++) begin
            @(posedge sys_clk) {en_one_n, en_two_n} <= e[1:0];
            text <= 1'b0;
            step(6);
            chk("text dominant", {2'b01, e[1:0]});
            @(posedge sys_clk) text <= 1'b1;
            step(6 + SUPP);
            chk("text released", 4'hF);
        end
        @(posedge sys_clk) {en_one_n, en_two_n} <= 2'b00;
        $display("done t_text");
    endtask

    task automatic t_rx();
        @(posedge sys_clk) node_two <= 1'b0;
        step(6);
        chk("bus two to one", 4'h1);
        @(posedge sys_clk) node_two <= 1'b1;
        step(6 + SUPP);
        chk("no interlock", 4'hF);
        @(posedge sys_clk) node_one <= 1'b0;
        step(6);
        chk("bus one to two", 4'h2);
        @(posedge sys_clk) node_one <= 1'b1;
        step(6 + SUPP);
        chk("no interlock two", 4'hF);
        @(posedge sys_clk) en_two_n <= 1'b1;
        node_two <= 1'b0;
        step(6);
        chk("disabled receive", 4'hF);
        @(posedge sys_clk) node_two <= 1'b1;
        en_two_n <= 1'b0;
        step(6);
        $display("done t_rx");
    endtask

    task automatic t_timeout();
        @(posedge sys_clk) tx <= 1'b0;
        step(10);
        chk("before timeout", 4'h0);
        step(TDOM + 5);
        chk("after timeout", 4'hF);
        @(posedge sys_clk) tx <= 1'b1;
        step(6 + SUPP);
        // Bus two stuck dominant must not keep blocking bus one
        @(posedge sys_clk) node_two <= 1'b0;
        step(TDOM + 10);
        chk("stuck bus timed out", 4'hF);
        @(posedge sys_clk) tx <= 1'b0;
        step(6);
        chk("traffic beside fault", 4'h0);
        @(posedge sys_clk) tx <= 1'b1;
        step(6 + SUPP);
        chk("fault release", 4'hF);
        @(posedge sys_clk) node_two <= 1'b1;
        step(10);
        $display("done t_timeout");
    endtask

    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        step(20);
        reset_n <= 1'b1;
        t_reset();
        t_tx();
        t_text();
        t_rx();
        t_timeout();
        end_sim();
    end

    // Tests take well under 600 cycles
    initial begin
        #(8 * 3000);
        num_errors++;
        end_sim();
    end
endmodule
